// [core/spce_top.sv]
// serial port control enables: control register, pin ownership, irq
// assumes apb master per amba, flags and shifter status from datapath
`timescale 1ns/100ps
`include "spce_defs.svh"
module spce_top
   import spce_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // datapath status
   input  wire logic        tx_buffer_empty_flag,
   input  wire logic        tx_done_flag,
   input  wire logic        rx_buffer_full_flag,
   input  wire logic        quiet_line_flag,
   input  wire logic        tx_busy,
   input  wire logic        idle_sent,
   // datapath controls
   output logic             tx_run,
   output logic             rx_run,
   output logic             idle_queue,
   // pin ownership
   output logic             txd_owned,
   output logic             txd_oe,
   output logic             rxd_owned,
   output logic             loopback_sel,
   output logic             rx_source_sel,
   // interrupts
   output logic             serial_irq,
   output logic             event_irq
);
   logic [7:0]     serial_ctrl_two_reg;
   logic [2:0]     mode_reg;
   logic [2:0]     evt_reg;
   logic [2:0]     evt_next;
   logic [2:0]     evmask_reg;
   logic           idle_q_reg;
   logic           done_d_reg;
   logic           full_d_reg;
   spce_tx_state_t tx_st_reg;
   spce_tx_state_t tx_st_next;
   logic           irq_req;

   spce_flag_if fl ();

   // apb decode
   wire logic acc      = psel & penable;
   // writes land only on the edge that completes the transfer
   wire logic wr       = acc & pwrite & pready;
   wire logic hit_ctrl = paddr == `SPCE_OFF_CTRL;
   wire logic hit_mode = paddr == `SPCE_OFF_MODE;
   wire logic hit_stat = paddr == `SPCE_OFF_STAT;
   wire logic hit_evt  = paddr == `SPCE_OFF_EVT;
   wire logic hit_msk  = paddr == `SPCE_OFF_EVMASK;
   wire logic hit_any  = hit_ctrl | hit_mode | hit_stat | hit_evt | hit_msk;
   wire logic wr_ctrl  = wr & hit_ctrl;
   wire logic [7:0] wbyte = pwdata[7:0];

   wire logic transmit_on     = serial_ctrl_two_reg[`SPCE_BIT_TRANSMIT_ON];
   wire logic transmit_on_new = wbyte[`SPCE_BIT_TRANSMIT_ON];
   wire logic rx_on           = serial_ctrl_two_reg[`SPCE_BIT_RX_ON];
   wire logic loop_m          = mode_reg[`SPCE_BIT_LOOP];
   wire logic src_m           = mode_reg[`SPCE_BIT_SOURCE];
   wire logic dir_m           = mode_reg[`SPCE_BIT_DIR];
   // enabled flags, watched by the interrupt checks below
   wire logic [3:0] en_flags  = {tx_buffer_empty_flag, tx_done_flag, rx_buffer_full_flag,
                                 quiet_line_flag} & serial_ctrl_two_reg[7:4];

   // writing enable 0 then 1 while busy queues one idle character
   wire logic on_fall  = wr_ctrl & transmit_on & ~transmit_on_new;
   wire logic on_rise  = wr_ctrl & ~transmit_on & transmit_on_new;
   wire logic q_set    = on_rise & (tx_busy | tx_st_reg == SPCE_TX_DRAIN);
   wire logic [2:0] evt_src = {on_fall, tx_done_flag & ~done_d_reg,
                               rx_buffer_full_flag & ~full_d_reg};

   wire logic [31:0] rd_mux =
      hit_ctrl ? {24'h000000, serial_ctrl_two_reg} :
      hit_mode ? {29'h00000000, mode_reg} :
      hit_stat ? {28'h0000000, tx_busy, idle_q_reg, tx_st_reg} :
      hit_evt  ? {29'h00000000, evt_reg} :
      hit_msk  ? {29'h00000000, evmask_reg} : 32'h00000000;

   // pin ownership; driving lasts through drain
   wire logic tx_active = tx_st_reg != SPCE_TX_OFF;
   wire logic tx_pin_n  = tx_active & ~(loop_m & ~src_m);
   wire logic tx_oe_n   = tx_pin_n & (~(loop_m & src_m) | dir_m);

   always_comb
   begin
      tx_st_next = tx_st_reg;
      unique case (tx_st_reg)
         SPCE_TX_OFF:   if (transmit_on) tx_st_next = SPCE_TX_RUN;
         SPCE_TX_RUN:   if (!transmit_on) tx_st_next = SPCE_TX_DRAIN;
         SPCE_TX_DRAIN:
         begin
            if (transmit_on)
               tx_st_next = SPCE_TX_RUN;
            else if (!tx_busy && !idle_q_reg)
               tx_st_next = SPCE_TX_OFF;
         end
         default:       tx_st_next = SPCE_TX_OFF;
      endcase
   end

   // set wins over write-one-to-clear
   always_comb
   begin
      evt_next = evt_reg;
      if (wr & hit_evt)
         evt_next = evt_reg & ~wbyte[2:0];
      evt_next = evt_next | evt_src;
   end

   assign fl.flags   = {tx_buffer_empty_flag, tx_done_flag,
                        rx_buffer_full_flag, quiet_line_flag};
   assign fl.enables = serial_ctrl_two_reg[7:4];

   spce_irq_comb u_irq
   (
      .pclk    (pclk),
      .presetn (presetn),
      .fl      (fl),
      .irq_req (irq_req)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         serial_ctrl_two_reg <= `SPCE_CTRL_RESET;
         mode_reg            <= `SPCE_MODE_RESET;
         evmask_reg          <= 3'h0;
      end
      else
      begin
         if (wr_ctrl)
            serial_ctrl_two_reg <= {wbyte[7:2], 2'h0};
         if (wr & hit_mode)
            mode_reg <= wbyte[2:0];
         if (wr & hit_msk)
            evmask_reg <= wbyte[2:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         evt_reg    <= 3'h0;
         idle_q_reg <= 1'b0;
         done_d_reg <= 1'b0;
         full_d_reg <= 1'b0;
         tx_st_reg  <= SPCE_TX_OFF;
      end
      else
      begin
         evt_reg    <= evt_next;
         done_d_reg <= tx_done_flag;
         full_d_reg <= rx_buffer_full_flag;
         tx_st_reg  <= tx_st_next;
         if (q_set)
            idle_q_reg <= 1'b1;
         else if (idle_sent)
            idle_q_reg <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata        <= 32'h00000000;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         tx_run        <= 1'b0;
         rx_run        <= 1'b0;
         idle_queue    <= 1'b0;
         txd_owned     <= 1'b0;
         txd_oe        <= 1'b0;
         rxd_owned     <= 1'b0;
         loopback_sel  <= 1'b0;
         rx_source_sel <= 1'b0;
         serial_irq    <= 1'b0;
         event_irq     <= 1'b0;
      end
      else
      begin
         // one wait state: pready pulses in the second access cycle
         pready        <= acc & ~pready;
         pslverr       <= acc & ~pready & ~hit_any;
         prdata        <= (psel & ~pwrite) ? rd_mux : 32'h00000000;
         tx_run        <= tx_active;
         rx_run        <= rx_on;
         rxd_owned     <= rx_on & ~(loop_m & src_m);
         idle_queue    <= idle_q_reg;
         txd_owned     <= tx_pin_n;
         txd_oe        <= tx_oe_n;
         loopback_sel  <= loop_m;
         rx_source_sel <= src_m;
         serial_irq    <= irq_req;
         event_irq     <= |(evt_reg & evmask_reg);
      end
   end

   // timing of the enable-off drain
   sequence s_transmit_off;
      $fell(transmit_on) && tx_busy;
   endsequence

   // two registers lie between a flag and the pin, so hold it two edges
   sequence s_empty_held;
      en_flags[3] ##1 en_flags[3];
   endsequence

   sequence s_done_held;
      en_flags[2] ##1 en_flags[2];
   endsequence

   sequence s_full_held;
      en_flags[1] ##1 en_flags[1];
   endsequence

   sequence s_quiet_held;
      en_flags[0] ##1 en_flags[0];
   endsequence

   sequence s_none_held;
      (en_flags == 4'h0) ##1 (en_flags == 4'h0);
   endsequence

   chk_drain_holds_pin: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_transmit_off |=> tx_st_reg == SPCE_TX_DRAIN)
      else $error("transmitter released pin while traffic pending");
   chk_drain_release: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tx_st_reg == SPCE_TX_DRAIN && !transmit_on && !tx_busy && !idle_q_reg)
      |=> tx_st_reg == SPCE_TX_OFF)
      else $error("drain did not end when traffic finished");
   chk_tx_only_enabled: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tx_st_reg == SPCE_TX_OFF) |=> !txd_owned)
      else $error("tx pin owned while transmitter off");
   chk_tx_stays_off: assert property (
      @(posedge pclk) disable iff (!presetn)
      (tx_st_reg == SPCE_TX_OFF && !transmit_on) |=> tx_st_reg == SPCE_TX_OFF)
      else $error("transmitter started without enable");
   chk_loop_frees_pin: assert property (
      @(posedge pclk) disable iff (!presetn)
      (loop_m && !src_m) |=> !txd_owned)
      else $error("tx pin kept in loop mode with internal source");
   chk_single_wire_dir: assert property (
      @(posedge pclk) disable iff (!presetn)
      (loop_m && src_m && tx_active) |=> txd_oe == $past(dir_m))
      else $error("single wire direction not followed");
   chk_oe_needs_own: assert property (
      @(posedge pclk) disable iff (!presetn)
      txd_oe |-> txd_owned)
      else $error("tx pin driven while not owned");
   chk_idle_queued: assert property (
      @(posedge pclk) disable iff (!presetn)
      q_set |=> idle_q_reg ##1 idle_queue)
      else $error("idle character not queued");
   chk_idle_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (idle_sent && !q_set) |=> !idle_q_reg)
      else $error("queued idle not cleared after it was sent");
   chk_rx_enable: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 rx_run == $past(rx_on))
      else $error("receiver enable not followed");
   chk_rx_pin_free: assert property (
      @(posedge pclk) disable iff (!presetn)
      !rx_on |=> !rxd_owned)
      else $error("rx pin kept while receiver off");
   chk_ctrl_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> serial_ctrl_two_reg[7:2] == $past(pwdata[7:2]))
      else $error("control write lost");
   chk_apb_one_wait: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready)
      else $error("access not answered after one wait state");
   chk_pready_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready held longer than one cycle");
   chk_unmapped_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready && !hit_any) |=> pslverr)
      else $error("unmapped access not flagged");
   chk_irq_out: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_empty_held |=> serial_irq)
      else $error("tx empty interrupt missing");
   chk_irq_done: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_done_held |=> serial_irq)
      else $error("tx done interrupt missing");
   chk_irq_full: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_full_held |=> serial_irq)
      else $error("rx full interrupt missing");
   chk_irq_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_quiet_held |=> serial_irq)
      else $error("idle line interrupt missing");
   chk_irq_none: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_none_held |=> !serial_irq)
      else $error("interrupt raised with no enabled flag");
endmodule : spce_top

// [core/spce_defs.svh]
// constants for the serial port control enables block
// assumes a 32-bit apb slave at pclk, one word per register
//
// Summary of operation
// - tx empty enabled raises interrupt request
// - tx done enabled raises interrupt request
// - rx full enabled raises interrupt request
// - idle line enabled raises interrupt request
// - transmitter starts only when enable set
// - loop with internal source frees tx pin
// - single wire: direction bit steers pin
// - enable off then on while busy queues idle
// - pin held until pending traffic finishes
// - receiver enable; off frees rx pin
// - control register accessible at any time
`ifndef SPCE_DEFS_SVH
`define SPCE_DEFS_SVH

`define SPCE_OFF_CTRL      12'h000
`define SPCE_OFF_MODE      12'h004
`define SPCE_OFF_STAT      12'h008
`define SPCE_OFF_EVT       12'h00c
`define SPCE_OFF_EVMASK    12'h010

`define SPCE_BIT_TX_EMPTY_IE  7
`define SPCE_BIT_TX_DONE_IE   6
`define SPCE_BIT_RX_FULL_IE   5
`define SPCE_BIT_QUIET_IE     4
`define SPCE_BIT_TRANSMIT_ON  3
`define SPCE_BIT_RX_ON        2

`define SPCE_BIT_LOOP      0
`define SPCE_BIT_SOURCE    1
`define SPCE_BIT_DIR       2

`define SPCE_CTRL_RESET    8'h00
`define SPCE_MODE_RESET    3'h0
`define SPCE_EVT_W         3

`endif

// [core/spce_pkg.sv]
// types for the serial port control enables block
// assumes spce_defs.svh is included by users that need offsets
package spce_pkg;
   typedef enum logic [1:0] {
      SPCE_TX_OFF   = 2'b00,
      SPCE_TX_RUN   = 2'b01,
      SPCE_TX_DRAIN = 2'b10
   } spce_tx_state_t;
endpackage : spce_pkg

// [core/spce_flag_if.sv]
// status flag bundle from the serial datapath to the irq combiner
// assumes flags are levels synchronous to pclk
`timescale 1ns/100ps
interface spce_flag_if;
   logic [3:0] flags;
   logic [3:0] enables;
   modport src (output flags, output enables);
   modport dst (input flags, input enables);
endinterface : spce_flag_if

// [core/spce_irq_comb.sv]
// irq combiner: or of flags gated by their enables
// assumes flags and enables both come from pclk registers
`timescale 1ns/100ps
module spce_irq_comb
   import spce_pkg::*;
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // flags
   spce_flag_if.dst  fl,
   // request
   output logic      irq_req
);
   wire logic [3:0] gated;
   assign gated = fl.flags & fl.enables;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_req <= 1'b0;
      else
         irq_req <= |gated;
   end

   chk_irq_follows_flags: assert property (
      @(posedge pclk) disable iff (!presetn)
      ##1 irq_req == $past(|gated))
      else $error("irq request does not track enabled flags");
endmodule : spce_irq_comb

// [verif/spce_line_model.sv]
// far side of the transmitter: frame timing of data and idle characters
// assumes tx_run and idle_queue are levels synchronous to pclk
`timescale 1ns/100ps
module spce_line_model
#(parameter int FRAME = 40)
(
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // controls
   input  wire logic tx_run,
   input  wire logic idle_queue,
   input  wire logic send,
   // status
   output logic      tx_busy,
   output logic      idle_sent
);
   logic [7:0] cnt_reg;
   logic       idle_reg;
   logic       sent_d_reg;
   assign tx_busy = (cnt_reg != 8'h00);
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_reg   <= 8'h00;
         idle_reg  <= 1'b0;
         idle_sent <= 1'b0;
         sent_d_reg <= 1'b0;
      end
      else
      begin
         sent_d_reg <= idle_sent;
         idle_sent <= idle_reg && (cnt_reg == 8'h01);
         if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
         else if (send && tx_run)
            cnt_reg <= 8'(FRAME);
         // queue output lags the pulse by two registers, so hold off two edges
         else if (idle_queue && !idle_sent && !sent_d_reg && tx_run)
         begin
            cnt_reg  <= 8'(FRAME);
            idle_reg <= 1'b1;
         end
         if (cnt_reg == 8'h01)
            idle_reg <= 1'b0;
      end
endmodule : spce_line_model

// [verif/spce_top_tb.sv]
// self-checking bench for the control enables block
// assumes one wait state apb slave and the line model as far side
`timescale 1ns/100ps
`include "spce_defs.svh"
module spce_top_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, send = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, r;
   logic [3:0]  fl = 4'h0;
   wire  [31:0] prdata;
   wire         pready, pslverr, tx_busy, idle_sent, tx_run, rx_run, idle_queue;
   wire         txd_owned, txd_oe, rxd_owned, loopback_sel, rx_source_sel;
   wire         serial_irq, event_irq;
   int          errors = 0, total_checks = 0;
   logic [32:0] expq[$];
   logic [2:0]  md[4] = '{3'h0, 3'h1, 3'h3, 3'h7};
   logic [4:0]  pe[4] = '{5'h1c, 5'h06, 5'h13, 5'h1b};
   always #2.5 pclk = ~pclk;
   spce_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_buffer_empty_flag(fl[3]), .tx_done_flag(fl[2]),
      .rx_buffer_full_flag(fl[1]), .quiet_line_flag(fl[0]), .tx_busy(tx_busy),
      .idle_sent(idle_sent), .tx_run(tx_run), .rx_run(rx_run), .idle_queue(idle_queue),
      .txd_owned(txd_owned), .txd_oe(txd_oe), .rxd_owned(rxd_owned),
      .loopback_sel(loopback_sel), .rx_source_sel(rx_source_sel),
      .serial_irq(serial_irq), .event_irq(event_irq));
   spce_line_model line_u (.pclk(pclk), .presetn(presetn), .tx_run(tx_run),
      .idle_queue(idle_queue), .send(send), .tx_busy(tx_busy), .idle_sent(idle_sent));
   task automatic chk(input string n, input logic [32:0] e, input logic [32:0] s);
      total_checks++;
      if (s !== e)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task conclude;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   // reads note their expectation; the monitor below compares
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      if (!w)
         expq.push_back(e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      // one idle edge so a following call never re-raises psel in this step
      @(posedge pclk);
   endtask : apb
   task ctl(input logic [7:0] v);
      apb(1'b1, `SPCE_OFF_CTRL, {24'h0, v}, 33'h0);
      cyc(3);
   endtask : ctl
   always @(posedge pclk)
      if (psel && penable && !pwrite && pready === 1'b1)
         chk("prdata", expq.pop_front(), {pslverr, prdata});
   initial
   begin
      #20000;
      errors++;
      conclude;
   end
   initial
   begin
      void'($urandom(21));
      cyc(5);
      presetn <= 1'b1;
      cyc(1);
      chk("reset", 33'h0, {tx_run, rx_run, idle_queue, txd_owned, txd_oe, serial_irq});
      apb(1'b0, `SPCE_OFF_CTRL, 32'h0, 33'h0);
      r = $urandom;
      apb(1'b1, `SPCE_OFF_CTRL, r, 33'h0);
      apb(1'b0, `SPCE_OFF_CTRL, 32'h0, {25'h0, r[7:2], 2'b00});
      apb(1'b0, 12'h100, 32'h0, {1'b1, 32'h0});
      for (int i = 0; i < 4; i++)
      begin
         fl <= 4'h1 << i;
         ctl(8'h10 << i);
         chk("irq on", 33'h1, serial_irq);
         ctl(~(8'h10 << i) & 8'hf0);
         chk("irq off", 33'h0, serial_irq);
      end
      repeat (8)
      begin
         r = $urandom;
         fl <= r[3:0];
         ctl({r[7:4], 4'h0});
         chk("irq mix", {32'h0, |(r[3:0] & r[7:4])}, serial_irq);
      end
      fl <= 4'h0;
      ctl(8'h0c);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, `SPCE_OFF_MODE, {29'h0, md[i]}, 33'h0);
         cyc(3);
         chk("pins", {28'h0, pe[i]}, {txd_owned, txd_oe, rxd_owned, loopback_sel,
            rx_source_sel});
      end
      apb(1'b0, `SPCE_OFF_MODE, 32'h0, 33'h7);
      apb(1'b1, `SPCE_OFF_MODE, 32'h0, 33'h0);
      ctl(8'h08);
      chk("rx off", 33'h4, {tx_run, rx_run, rxd_owned});
      send <= 1'b1;
      cyc(1);
      send <= 1'b0;
      cyc(2);
      ctl(8'h00);
      chk("drain", 33'h7, {tx_run, txd_owned, txd_oe});
      apb(1'b0, `SPCE_OFF_STAT, 32'h0, 33'h0a);
      while (tx_busy)
         @(posedge pclk);
      cyc(3);
      chk("released", 33'h0, {tx_run, txd_owned, txd_oe});
      send <= 1'b1;
      ctl(8'h08);
      send <= 1'b0;
      ctl(8'h00);
      ctl(8'h08);
      chk("idle queued", 33'h1, idle_queue);
      while (!idle_sent)
         @(posedge pclk);
      cyc(2);
      chk("idle done", 33'h0, idle_queue);
      apb(1'b1, `SPCE_OFF_EVT, 32'h7, 33'h0);
      apb(1'b0, `SPCE_OFF_EVT, 32'h0, 33'h0);
      apb(1'b1, `SPCE_OFF_EVMASK, 32'h1, 33'h0);
      fl <= 4'h2;
      cyc(3);
      chk("event raised", 33'h1, event_irq);
      apb(1'b1, `SPCE_OFF_EVMASK, 32'h0, 33'h0);
      cyc(2);
      chk("event masked", 33'h0, event_irq);
      apb(1'b0, `SPCE_OFF_EVT, 32'h0, 33'h1);
      apb(1'b1, `SPCE_OFF_EVT, 32'h1, 33'h0);
      apb(1'b1, `SPCE_OFF_EVMASK, 32'h1, 33'h0);
      cyc(2);
      chk("event cleared", 33'h0, event_irq);
      conclude;
   end
endmodule : spce_top_tb
